// *** mcas_pkg.sv ***
// Package for the memory channel access steering block.
// Assumes a single processor clock domain; no software-visible registers.
package mcas_pkg;

    // ------------------------------------------------------------------
    // Address fields
    // ------------------------------------------------------------------
    localparam int ADDR_HI_LSB = 9;
    localparam int ADDR_HI_MSB = 21;
    localparam int COL_LSB = 1;
    localparam int COL_MSB = 8;
    localparam int ROW_LSB = 9;
    localparam int ROW_MSB = 16;
    localparam int BANK_LSB = 17;
    localparam int BANK_MSB = 21;
    localparam int PRES_LSB = 19;
    localparam int PRES_MSB = 21;
    localparam int BANK_COUNT = 5;
    localparam int PRES_COUNT = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_SYNC = 1'b0;
    localparam logic RST_SELECT_N = 1'b1;
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic [1:0] RST_ROWCOL_N = 2'h3;

    // Processor bus control bundle copied onto the channel.
    typedef struct packed {
        logic readStrobe;
        logic writeStrobe;
        logic upperByte;
        logic lowerByte;
    } mcas_ctrl_t;

    // Channel-side strobe bundle.
    typedef struct packed {
        logic sync;
        logic selectN;
        logic rowStrobeN;
        logic colStrobeN;
    } mcas_strobe_t;

endpackage

// *** mcas_bit_pad.sv ***
// Channel-side drive half of one bidirectional data bit.
// Assumes the wire is resolved outside from the enable (low means driving).
`timescale 1ns/1ps
`default_nettype none
module mcas_bit_pad (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic driveChannel,
    input wire logic cpuIn,
    output logic channelOut,
    output logic channelOeN
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channelOut <= 1'b0;
            channelOeN <= 1'b1;
        end else begin
            channelOut <= cpuIn;
            channelOeN <= ~driveChannel;
        end
    end
endmodule
`default_nettype wire

// *** mcas_steering.sv ***
// Memory channel access steering: decodes each access, drives the channel
// strobes, bank selects and multiplexed address, and flags backplane cycles.
// Assumes all inputs are synchronous to the 40 MHz processor clock.
//
// Overview of operation
// - Channel data couples to the processor data bus only while the buffer enable is low.
// - The channel address carries bits 1 to 8 in one phase and bits 9 to 16 in the other.
// - Five bank selects are decoded from address bits 17 to 21.
// - Every access with no error detected starts on the backplane; the backplane cycle aborts when memory is on the channel or on an error.
// - Address bits 19 to 21 pick one of the channel memory-present inputs.
// - The backplane-cycle flag is raised on an access whose picked memory-present input is low.
// - With memory present, sync and select are registered on the next clock edge.
// - Backplane request, bus error or channel disable hold the sync/select register clear.
// - Row and column strobes come from a clocked register.
// - Other channel controls are registered copies of processor controls.
// - An error suppresses channel write and inhibits backplane transactions.
// - Data moves over a 16-bit bidirectional path to channel or resident bus.
`timescale 1ns/1ps
`default_nettype none
module mcas_steering #(
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic accessStart,
    input wire logic [mcas_pkg::ADDR_HI_MSB:1] cpuPhysAddr,
    input wire logic [mcas_pkg::PRES_COUNT-1:0] memPresent,
    input wire logic backplaneRequest,
    input wire logic busError,
    input wire logic channelDisable,
    input wire logic errorDetect,
    input wire logic dataBufEnable_n,
    input wire logic cpuWriting,
    input wire mcas_pkg::mcas_ctrl_t cpuCtrl,
    input wire logic [DATA_W-1:0] cpuDataIn,
    input wire logic [DATA_W-1:0] memoryChannelDataIn,
    input wire logic [DATA_W-1:0] residentDataIn,
    output logic [DATA_W-1:0] cpuDataOut,
    output logic [DATA_W-1:0] memoryChannelDataOut,
    output logic [DATA_W-1:0] memoryChannelDataOe_n,
    output logic [DATA_W-1:0] residentDataOut,
    output logic residentDataOe_n,
    output logic [7:0] channelAddr,
    output logic [mcas_pkg::BANK_COUNT-1:0] memoryBankSelect,
    output mcas_pkg::mcas_strobe_t channelStrobe,
    output mcas_pkg::mcas_ctrl_t channelCtrl,
    output logic offboardCycleFlag,
    output logic backplaneStart,
    output logic backplaneAbort
);
    typedef enum logic [1:0] {MCAS_IDLE, MCAS_ROW, MCAS_COL} mcas_phase_t;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [2:0] presIdx;
    logic present;
    logic holdClear;
    logic [4:0] bankField;
    assign presIdx = cpuPhysAddr[mcas_pkg::PRES_MSB:mcas_pkg::PRES_LSB];
    assign present = memPresent[presIdx];
    assign holdClear = backplaneRequest | busError | channelDisable;
    assign bankField = cpuPhysAddr[mcas_pkg::BANK_MSB:mcas_pkg::BANK_LSB];

    mcas_phase_t phase_q;
    logic [DATA_W-1:0] chanOutRaw;
    logic [DATA_W-1:0] chanOeRaw;
    logic chanSel_q;
    logic sync_q;
    logic selectN_q;
    logic rowStrobeN_q;
    logic colStrobeN_q;

    // Each strobe has its own register so that exactly one process owns each bit.
    assign channelStrobe = '{sync: sync_q, selectN: selectN_q, rowStrobeN: rowStrobeN_q,
        colStrobeN: colStrobeN_q};

    // ------------------------------------------------------------------
    // Sync/select register and backplane steering
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= mcas_pkg::RST_SYNC;
            selectN_q <= mcas_pkg::RST_SELECT_N;
            chanSel_q <= 1'b0;
        end else if (holdClear) begin
            sync_q <= mcas_pkg::RST_SYNC;
            selectN_q <= mcas_pkg::RST_SELECT_N;
            chanSel_q <= 1'b0;
        end else if (accessStart) begin
            sync_q <= present;
            selectN_q <= ~present;
            chanSel_q <= present;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            offboardCycleFlag <= 1'b0;
            backplaneStart <= 1'b0;
            backplaneAbort <= 1'b0;
        end else begin
            offboardCycleFlag <= accessStart & ~present;
            backplaneStart <= accessStart & ~errorDetect;
            backplaneAbort <= accessStart & (present | errorDetect);
        end
    end

    // ------------------------------------------------------------------
    // Row/column strobes and multiplexed address
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= MCAS_IDLE;
            rowStrobeN_q <= mcas_pkg::RST_STROBE_N;
            colStrobeN_q <= mcas_pkg::RST_STROBE_N;
            channelAddr <= 8'h00;
            memoryBankSelect <= 5'h00;
        end else begin
            case (phase_q)
                MCAS_IDLE: begin
                    rowStrobeN_q <= 1'b1;
                    colStrobeN_q <= 1'b1;
                    if (accessStart && present && !holdClear) begin
                        phase_q <= MCAS_ROW;
                        channelAddr <= cpuPhysAddr[mcas_pkg::ROW_MSB:mcas_pkg::ROW_LSB];
                        memoryBankSelect <= bankField;
                    end
                end
                MCAS_ROW: begin
                    rowStrobeN_q <= 1'b0;
                    channelAddr <= cpuPhysAddr[mcas_pkg::COL_MSB:mcas_pkg::COL_LSB];
                    phase_q <= holdClear ? MCAS_IDLE : MCAS_COL;
                end
                MCAS_COL: begin
                    colStrobeN_q <= 1'b0;
                    if (!chanSel_q) begin
                        phase_q <= MCAS_IDLE;
                    end
                end
                default: phase_q <= MCAS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control copies
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channelCtrl <= '0;
        end else begin
            channelCtrl <= cpuCtrl;
            channelCtrl.writeStrobe <= cpuCtrl.writeStrobe & ~errorDetect;
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    // Each bit is a registered pad so the wide enable never glitches.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : gBit
            mcas_bit_pad uPad (
                .clk(clk),
                .reset_n(reset_n),
                .driveChannel(~dataBufEnable_n & cpuWriting),
                .cpuIn(cpuDataIn[gi]),
                .channelOut(chanOutRaw[gi]),
                .channelOeN(chanOeRaw[gi])
            );
        end
    endgenerate
    assign memoryChannelDataOut = chanOutRaw;
    assign memoryChannelDataOe_n = chanOeRaw;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpuDataOut <= '0;
            residentDataOut <= '0;
            residentDataOe_n <= 1'b1;
        end else begin
            // Channel wins only while its buffer is enabled.
            cpuDataOut <= !dataBufEnable_n ? memoryChannelDataIn : residentDataIn;
            residentDataOut <= cpuDataIn;
            residentDataOe_n <= ~(dataBufEnable_n & cpuWriting);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_sync_present: assert property (@(posedge clk) disable iff (!reset_n)
        accessStart && present && !holdClear |=> channelStrobe.sync && !channelStrobe.selectN)
        else $error("sync not set for present memory");
    a_hold_clear: assert property (@(posedge clk) disable iff (!reset_n)
        holdClear |=> !channelStrobe.sync && channelStrobe.selectN)
        else $error("sync not held clear");
    a_offboard_flag: assert property (@(posedge clk) disable iff (!reset_n)
        accessStart && !present |=> offboardCycleFlag)
        else $error("backplane flag missing");
    a_abort_channel: assert property (@(posedge clk) disable iff (!reset_n)
        accessStart && present |=> backplaneAbort && !offboardCycleFlag)
        else $error("backplane not aborted");
    // The sequencer only starts from idle, so an access begun mid-cycle is not claimed.
    a_row_then_col: assert property (@(posedge clk) disable iff (!reset_n)
        phase_q == MCAS_IDLE && accessStart && present && !holdClear ##1 !holdClear
        |=> !channelStrobe.rowStrobeN && channelStrobe.colStrobeN ##1 !channelStrobe.colStrobeN)
        else $error("row/column order wrong");
    a_write_suppress: assert property (@(posedge clk) disable iff (!reset_n)
        errorDetect |=> !channelCtrl.writeStrobe)
        else $error("write not suppressed");
    a_ctrl_copy: assert property (@(posedge clk) disable iff (!reset_n)
        !errorDetect |=> channelCtrl == $past(cpuCtrl))
        else $error("control copy wrong");
    a_bank_decode: assert property (@(posedge clk) disable iff (!reset_n)
        phase_q == MCAS_IDLE && accessStart && present && !holdClear
        |=> memoryBankSelect == $past(bankField))
        else $error("bank select wrong");
    a_data_steer: assert property (@(posedge clk) disable iff (!reset_n)
        !dataBufEnable_n |=> cpuDataOut == $past(memoryChannelDataIn))
        else $error("channel data not steered");
endmodule
`default_nettype wire

// *** mcas_mem_card.sv ***
// Behavioural dual-ported memory card pair seen from the channel side.
// Assumes presence comes from the bench and strobes come from the steering block.
`timescale 1ns/1ps
`default_nettype none
module mcas_mem_card (
    input wire logic clk,
    input wire logic slow,
    input wire logic [7:0] presentMap,
    input wire mcas_pkg::mcas_strobe_t channelStrobe,
    input wire logic [7:0] channelAddr,
    output logic [7:0] memPresent,
    output logic [15:0] readData
);
    // ------------------------------------------------------------
    // Card behaviour
    // ------------------------------------------------------------
    logic [7:0] rowQ = 8'h00;
    logic colSeenQ = 1'b0;
    logic [15:0] lastQ = 16'h0000;
    assign memPresent = presentMap;
    // An idle data bus toggles every cycle so a stale value never looks valid.
    always @(posedge clk) begin
        colSeenQ <= !channelStrobe.colStrobeN;
        if (channelStrobe.rowStrobeN) begin
            rowQ <= channelAddr;
        end
        if (!channelStrobe.selectN && !channelStrobe.colStrobeN && (!slow || colSeenQ)) begin
            lastQ <= {rowQ, channelAddr};
        end else begin
            lastQ <= ~lastQ;
        end
    end
    assign readData = lastQ;
endmodule
`default_nettype wire

// *** memory_channel_access_steering_tb_top.sv ***
// Self-checking bench for the memory channel access steering block.
// Assumes a 40 MHz clock and the memory card model on the channel side.
`timescale 1ns/1ps
`default_nettype none
module memory_channel_access_steering_tb_top;
    typedef struct packed {
        logic off; logic st; logic ab; logic sy; logic [4:0] bk; logic [7:0] row; logic [7:0] col;
    } mcas_exp_t;
    logic clk = 0, reset_n = 0, accessStart = 0, backplaneRequest = 0, busError = 0;
    logic channelDisable = 0, errorDetect = 0, dataBufEnable_n = 1, cpuWriting = 0, slow = 0;
    logic [21:1] cpuPhysAddr = '0;
    logic [7:0] presentMap = 8'hA5, memPresent, channelAddr;
    mcas_pkg::mcas_ctrl_t cpuCtrl = '0, channelCtrl, pc;
    mcas_pkg::mcas_strobe_t channelStrobe;
    logic [15:0] cpuDataIn = '0, residentDataIn = '0, chIn, cpuDataOut, chOut, chOe_n, resOut;
    logic [15:0] pd, pw;
    logic [4:0] memoryBankSelect;
    logic resOe_n, offboardCycleFlag, backplaneStart, backplaneAbort, po, pe, pr = 0;
    logic [4:0] lastBk = '0;
    logic [7:0] lastCol = '0;
    int failures = 0, checked = 0;
    mcas_exp_t expQ[$], e;
    always #12.5 clk = ~clk;
    mcas_steering dut (.clk(clk), .reset_n(reset_n), .accessStart(accessStart),
        .cpuPhysAddr(cpuPhysAddr), .memPresent(memPresent), .backplaneRequest(backplaneRequest),
        .busError(busError), .channelDisable(channelDisable), .errorDetect(errorDetect),
        .dataBufEnable_n(dataBufEnable_n), .cpuWriting(cpuWriting), .cpuCtrl(cpuCtrl),
        .cpuDataIn(cpuDataIn), .memoryChannelDataIn(chIn), .residentDataIn(residentDataIn),
        .cpuDataOut(cpuDataOut), .memoryChannelDataOut(chOut), .memoryChannelDataOe_n(chOe_n),
        .residentDataOut(resOut), .residentDataOe_n(resOe_n), .channelAddr(channelAddr),
        .memoryBankSelect(memoryBankSelect), .channelStrobe(channelStrobe),
        .channelCtrl(channelCtrl), .offboardCycleFlag(offboardCycleFlag),
        .backplaneStart(backplaneStart), .backplaneAbort(backplaneAbort));
    mcas_mem_card card (.clk(clk), .slow(slow), .presentMap(presentMap),
        .channelStrobe(channelStrobe), .channelAddr(channelAddr), .memPresent(memPresent),
        .readData(chIn));
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] seen);
        checked++;
        if (ex !== seen) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Drivers and monitors
    // ------------------------------------------------------------
    task access(input logic [21:1] a);
        logic pres, hold, old, sy;
        pres = presentMap[a[21:19]];
        hold = backplaneRequest | busError | channelDisable;
        sy = pres & !hold;
        // Bank and address registers only move when a channel access starts.
        expQ.push_back('{!pres, !errorDetect, pres | errorDetect, sy, sy ? a[21:17] : lastBk,
            sy ? a[16:9] : lastCol, a[8:1]});
        if (sy) begin
            lastBk = a[21:17];
            lastCol = a[8:1];
        end
        @(negedge clk) cpuPhysAddr = a;
        accessStart = 1;
        @(negedge clk) accessStart = 0;
        repeat (4) @(negedge clk);
        // The access is closed by a one-cycle backplane request.
        old = backplaneRequest;
        backplaneRequest = 1;
        @(negedge clk) backplaneRequest = old;
        repeat (2) @(negedge clk);
    endtask
    always @(negedge clk) begin
        cpuCtrl <= 4'($urandom);
        cpuDataIn <= 16'($urandom);
        residentDataIn <= 16'($urandom);
        dataBufEnable_n <= 1'($urandom);
        cpuWriting <= 1'($urandom);
    end
    // Copies are taken at the sampling edge, where the inputs are settled.
    always @(posedge clk) begin
        pr <= reset_n;
        pc <= cpuCtrl;
        pc.writeStrobe <= cpuCtrl.writeStrobe & !errorDetect;
        pd <= dataBufEnable_n ? residentDataIn : chIn;
        pw <= cpuDataIn;
        po <= !(!dataBufEnable_n && cpuWriting);
        pe <= !(dataBufEnable_n && cpuWriting);
    end
    always @(negedge clk) begin
        if (pr && reset_n) begin
            chk("channelCtrl", pc, channelCtrl);
            chk("cpuDataOut", pd, cpuDataOut);
            chk("chanDataOe_n", {16{po}}, chOe_n);
            chk("chanDataOut", pw, chOut);
            chk("residentOut", pw, resOut);
            chk("residentOe_n", pe, resOe_n);
        end
    end
    always @(negedge clk) begin
        if (reset_n && (backplaneStart || backplaneAbort)) begin
            if (expQ.size() == 0) begin
                failures++;
                $display("ERROR access expected none seen one");
            end else begin
                e = expQ.pop_front();
                chk("offboardFlag", e.off, offboardCycleFlag);
                chk("bpStart", e.st, backplaneStart);
                chk("bpAbort", e.ab, backplaneAbort);
                chk("sync", e.sy, channelStrobe.sync);
                chk("selectN", !e.sy, channelStrobe.selectN);
                chk("bank", e.bk, memoryBankSelect);
                chk("rowAddr", e.row, channelAddr);
                @(negedge clk);
                chk("rowStrobeN", !e.sy, channelStrobe.rowStrobeN);
                if (e.sy) chk("colAddr", e.col, channelAddr);
                @(negedge clk);
                chk("colStrobeN", !e.sy, channelStrobe.colStrobeN);
                // The card answers with row and column paired, one cycle later when slow.
                repeat (2) @(negedge clk);
                if (e.sy) chk("cardData", {e.row, e.col}, chIn);
            end
        end
    end
    initial begin
        #(25ns * 100000);
        failures++;
        $display("ERROR run expected finish seen timeout");
        end_sim();
    end
    initial begin
        void'($urandom(32'h1b0b));
        repeat (12) @(negedge clk);
        reset_n = 1;
        chk("idleStrobes", 4'h7, channelStrobe);
        for (int m = 0; m < 2; m++) begin
            presentMap = m ? 8'h5A : 8'hA5;
            slow = m;
            for (int i = 0; i < 8; i++) access({3'(i), 18'($urandom)});
        end
        for (int k = 0; k < 3; k++) begin
            {backplaneRequest, busError, channelDisable} = 3'h1 << k;
            access({3'h1, 18'h3FFFF});
            {backplaneRequest, busError, channelDisable} = 3'h0;
        end
        errorDetect = 1;
        access({3'h1, 18'h00001});
        access({3'h2, 18'h2AAAA});
        errorDetect = 0;
        for (int t = 0; t < 20 && expQ.size() > 0; t++) @(negedge clk);
        if (expQ.size() != 0) begin
            failures++;
            $display("ERROR pending expected 0 seen %0d", expQ.size());
        end
        end_sim();
    end
endmodule
`default_nettype wire
